// file: bench/stack_operand_alu_ops_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port checker for the stack alu group
// ----------------------------------------------------------------------------
module stack_alu_checker
  import stack_alu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_prefix,
  input wire logic [7:0] i_selector,
  input wire logic [15:0] i_stack_pointer,
  input wire logic [15:0] i_pc,
  input wire logic i_carry_flag,
  input wire logic i_aux_carry_flag,
  input wire logic i_overflow_flag,
  input wire logic [15:0] o_ram_addr,
  input wire logic o_ram_rd,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [15:0] o_stack_pointer,
  input wire logic [15:0] o_pc,
  input wire logic o_carry_flag,
  input wire logic o_aux_carry_flag,
  input wire logic o_overflow_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // request taken while idle, byte and word forms
  sequence s_byte_go;
    i_start && !o_busy && i_prefix == PREFIX_CODE && (i_selector == SEL_STACK_BYTE_SUBTRACT
      || i_selector == SEL_STACK_BYTE_SUBTRACT_BORROW);
  endsequence
  sequence s_word_go;
    i_start && !o_busy && i_prefix == PREFIX_CODE && (i_selector == SEL_STACK_WORD_OR
      || i_selector == SEL_STACK_WORD_SUBTRACT || i_selector == SEL_STACK_WORD_SUBTRACT_BORROW);
  endsequence
  sequence s_or_go;
    i_start && !o_busy && i_prefix == PREFIX_CODE && i_selector == SEL_STACK_WORD_OR;
  endsequence
  a_byte_read_addr: assert property (s_byte_go |=> o_ram_rd && o_ram_addr ==
    $past(i_stack_pointer) ##1 !o_ram_rd) else $error("byte read address wrong");
  a_word_read_order: assert property (s_word_go |=> o_ram_rd && o_ram_addr ==
    $past(i_stack_pointer) - SP_STEP ##1 o_ram_rd && o_ram_addr == $past(i_stack_pointer, 2))
    else $error("word read order wrong");
  a_byte_done_time: assert property (s_byte_go |=> !o_done [*2] ##1 o_done)
    else $error("byte completion time wrong");
  a_word_done_time: assert property (s_word_go |=> !o_done [*3] ##1 o_done)
    else $error("word completion time wrong");
  a_word_busy_span: assert property (s_word_go |=> o_busy [*3] ##1 !o_busy)
    else $error("word busy span wrong");
  a_byte_sp_pc: assert property (s_byte_go |-> ##3 o_pc == $past(i_pc, 3) + PC_STEP
    && o_stack_pointer == $past(i_stack_pointer, 3) - SP_STEP) else $error("byte sp or pc wrong");
  a_word_sp_pc: assert property (s_word_go |-> ##4 o_pc == $past(i_pc, 4) + PC_STEP
    && o_stack_pointer == $past(i_stack_pointer, 4) - 16'h0002) else $error("word sp or pc wrong");
  a_or_keeps_flags: assert property (s_or_go |-> ##4 {o_carry_flag, o_aux_carry_flag,
    o_overflow_flag} == $past({i_carry_flag, i_aux_carry_flag, i_overflow_flag}, 4))
    else $error("word or changed flags");
endmodule : stack_alu_checker
bind stack_operand_alu_ops stack_alu_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_start(i_start), .i_prefix(i_prefix), .i_selector(i_selector),
  .i_stack_pointer(i_stack_pointer), .i_pc(i_pc), .i_carry_flag(i_carry_flag),
  .i_aux_carry_flag(i_aux_carry_flag), .i_overflow_flag(i_overflow_flag),
  .o_ram_addr(o_ram_addr), .o_ram_rd(o_ram_rd), .o_busy(o_busy), .o_done(o_done),
  .o_stack_pointer(o_stack_pointer), .o_pc(o_pc), .o_carry_flag(o_carry_flag),
  .o_aux_carry_flag(o_aux_carry_flag), .o_overflow_flag(o_overflow_flag));

// file: bench/stack_ram_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// synchronous stack ram, one cycle read latency
// ----------------------------------------------------------------------------
module stack_ram_model (
  input wire logic i_clk_sys,  // core clock
  input wire logic i_rd,  // read strobe from the block
  input wire logic [15:0] i_addr,  // read address
  output logic [7:0] o_rdata  // byte, valid one cycle after the strobe
);
  logic [7:0] mem [0:65535];  // loaded by the bench
  logic [7:0] data_q = 8'h5a;  // output register
  // no read: data flips every cycle so a late sample is never lucky
  always @(posedge i_clk_sys) begin
    if (i_rd) begin
      data_q <= mem[i_addr];
    end else begin
      data_q <= ~data_q;
    end
  end
  assign o_rdata = data_q;
endmodule : stack_ram_model

// file: bench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// self-checking bench for the stack alu group
// ----------------------------------------------------------------------------
module tb
  import stack_alu_pkg::*;
;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_start = 1'b0;  // clock, reset, request
  logic [7:0] i_prefix = 8'h00, i_selector = 8'h00, i_acc = 8'h00, i_breg = 8'h00;
  logic [15:0] i_stack_pointer = 16'h0000, i_pc = 16'h0000;
  logic i_carry_flag = 1'b0, i_aux_carry_flag = 1'b0, i_overflow_flag = 1'b0;
  logic [7:0] i_ram_rdata, o_acc, o_breg;  // ram byte and results
  logic [15:0] o_ram_addr, o_stack_pointer, o_pc;
  logic o_ram_rd, o_busy, o_done, o_unsupported, o_carry_flag, o_aux_carry_flag, o_overflow_flag;
  int n_errors = 0, tests_run = 0, cycles = 0;  // verdict counters
  logic [31:0] rs = 32'hed94;  // xorshift state, fixed seed
  logic [7:0] sels [5] = '{SEL_STACK_WORD_OR, SEL_STACK_BYTE_SUBTRACT,
    SEL_STACK_BYTE_SUBTRACT_BORROW, SEL_STACK_WORD_SUBTRACT, SEL_STACK_WORD_SUBTRACT_BORROW};
  stack_operand_alu_ops dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(i_start),
    .i_prefix(i_prefix), .i_selector(i_selector), .i_acc(i_acc), .i_breg(i_breg),
    .i_stack_pointer(i_stack_pointer), .i_pc(i_pc), .i_carry_flag(i_carry_flag),
    .i_aux_carry_flag(i_aux_carry_flag), .i_overflow_flag(i_overflow_flag),
    .i_ram_rdata(i_ram_rdata), .o_ram_addr(o_ram_addr), .o_ram_rd(o_ram_rd), .o_busy(o_busy),
    .o_done(o_done), .o_unsupported(o_unsupported), .o_acc(o_acc), .o_breg(o_breg),
    .o_stack_pointer(o_stack_pointer), .o_pc(o_pc), .o_carry_flag(o_carry_flag),
    .o_aux_carry_flag(o_aux_carry_flag), .o_overflow_flag(o_overflow_flag));
  stack_ram_model ram (.i_clk_sys(i_clk_sys), .i_rd(o_ram_rd), .i_addr(o_ram_addr),
    .o_rdata(i_ram_rdata));
  // ----------------------------------------------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------------------------------------------
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // about 260 ops of at most 6 cycles; a hang ends the run
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  // reference subtract: {ov, aux, carry, diff} for 8- or 16-bit forms
  function automatic logic [18:0] ref_sub(input logic [15:0] a, b, input logic c, input int w);
    logic [15:0] m, n, d;
    m = (w == 8) ? 16'h00ff : 16'hffff;
    n = (w == 8) ? 16'h000f : 16'h0fff;
    d = (a - b - {15'h0000, c}) & m;
    return {a[w-1] != b[w-1] && d[w-1] != a[w-1], {1'b0, a & n} < {1'b0, b & n} + c,
      {1'b0, a & m} < {1'b0, b & m} + c, d};
  endfunction : ref_sub
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------------------
  // one instruction: load stack, request, wait, compare; ends at the done cycle
  // ----------------------------------------------------------------------------
  task automatic do_op(input logic [7:0] pre, sel, a, b, hi, lo, input logic [15:0] sp,
      input logic c, poke);
    logic [18:0] r;
    logic [15:0] pc, res, esp;
    logic [2:0] fl, efl;
    logic ok, wrd;
    int i, lat;
    pc = 16'(rnd());
    fl = {c, 2'(rnd())};  // carry on top, the other two flags drawn
    ok = pre == PREFIX_CODE && sel inside {sels};
    wrd = ok && sel[7];
    lat = !ok ? 1 : wrd ? 4 : 3;
    ram.mem[sp - 16'h0001] = lo;  // low byte below the top
    ram.mem[sp] = hi;
    r = ref_sub(wrd ? {b, a} : {8'h00, a}, wrd ? {hi, lo} : {8'h00, hi},
      c && sel[4], wrd ? 16 : 8);
    res = sel == SEL_STACK_WORD_OR ? {b, a} | {hi, lo} : wrd ? r[15:0] : {b, r[7:0]};
    efl = sel == SEL_STACK_WORD_OR ? fl : {r[16], r[17], r[18]};
    esp = wrd ? sp - 16'h0002 : sp - SP_STEP;
    if (!ok) begin
      res = {o_breg, o_acc};
      efl = {o_carry_flag, o_aux_carry_flag, o_overflow_flag};
      esp = o_stack_pointer;
      pc = o_pc - PC_STEP;
    end
    {i_prefix, i_selector, i_acc, i_breg, i_stack_pointer, i_pc} = {pre, sel, a, b, sp, pc};
    {i_carry_flag, i_aux_carry_flag, i_overflow_flag} = fl;
    i_start = 1'b1;
    for (i = 1; i <= 6; i++) begin
      @(negedge i_clk_sys);
      if (o_done === 1'b1 || o_unsupported === 1'b1) break;
      // request while busy must be ignored; start is left alone on the finishing
      // edge, so the next call raises it without a second write in one step
      i_start = poke && i == 1;
    end
    chk("latency", 16'(lat), 16'(i));
    chk("unsupported", {15'h0000, !ok}, {15'h0000, o_unsupported});
    chk("pair", res, {o_breg, o_acc});
    chk("flags", {13'h0000, efl},
      {13'h0000, o_carry_flag, o_aux_carry_flag, o_overflow_flag});
    chk("stack pointer", esp, o_stack_pointer);
    chk("program counter", pc + PC_STEP, o_pc);
    $display("op %h %h ends", pre, sel);
  endtask : do_op
  // ----------------------------------------------------------------------------
  // main sequence: examples, wrap, refusals, random back-to-back, reset
  // ----------------------------------------------------------------------------
  initial begin
    logic [31:0] v, w, x;  // draws for one random op, taken before the call
    repeat (5) @(negedge i_clk_sys);
    i_rst = 1'b0;
    do_op(PREFIX_CODE, SEL_STACK_BYTE_SUBTRACT, 8'h49, 8'h11,
      8'h68, 8'h00, 16'h0020, 1'b1, 1'b0);
    do_op(PREFIX_CODE, SEL_STACK_BYTE_SUBTRACT_BORROW, 8'he1, 8'h22,
      8'h68, 8'h00, 16'h0020, 1'b1, 1'b1);
    do_op(PREFIX_CODE, SEL_STACK_WORD_SUBTRACT, 8'h00, 8'h7e,
      8'h95, 8'h00, 16'h0021, 1'b1, 1'b0);
    do_op(PREFIX_CODE, SEL_STACK_WORD_SUBTRACT_BORROW, 8'h00, 8'he1,
      8'h68, 8'h00, 16'h0021, 1'b1, 1'b1);
    do_op(PREFIX_CODE, SEL_STACK_WORD_OR, 8'h00, 8'h00,
      8'h01, 8'h01, 16'h0000, 1'b1, 1'b0);
    do_op(PREFIX_CODE, SEL_STACK_BYTE_SUBTRACT, 8'h00, 8'h00,
      8'h01, 8'h00, 16'h0000, 1'b0, 1'b0);
    do_op(8'h97, SEL_STACK_BYTE_SUBTRACT, 8'h12, 8'h34, 8'h56, 8'h78, 16'h0100, 1'b0, 1'b0);
    do_op(PREFIX_CODE, 8'h40, 8'h12, 8'h34, 8'h56, 8'h78, 16'h0100, 1'b0, 1'b0);
    repeat (250) begin
      v = rnd();  // op choice, carry and poke
      w = rnd();  // operands and stacked bytes
      x = rnd();  // stack pointer
      do_op(v[3:0] == 4'h0 ? v[31:24] : PREFIX_CODE, v[6:4] == 3'h0 ? v[23:16] :
        sels[v[9:7] % 5], w[7:0], w[15:8], w[23:16], w[31:24], x[15:0], v[10], v[11]);
    end
    i_start = 1'b1;  // word request cut short by reset
    i_selector = SEL_STACK_WORD_SUBTRACT;
    i_prefix = PREFIX_CODE;
    @(negedge i_clk_sys);
    i_start = 1'b0;
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    chk("reset state", 16'h0000, {o_acc, 5'h00, o_busy, o_done, o_ram_rd});
    i_rst = 1'b0;
    do_op(PREFIX_CODE, SEL_STACK_WORD_SUBTRACT, 8'h00, 8'h49,
      8'h68, 8'h00, 16'h0021, 1'b0, 1'b0);
    end_sim();
  end
endmodule : tb

// file: pkg/stack_alu_pkg.sv
// ----------------------------------------------------------------------------
// shared constants for the stack-operand alu group
// ----------------------------------------------------------------------------
package stack_alu_pkg;

  // ----------------------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------------------
  localparam logic [7:0] PREFIX_CODE = 8'h98;  // common first byte
  localparam logic [7:0] SEL_STACK_WORD_OR = 8'he0;  // word or
  localparam logic [7:0] SEL_STACK_BYTE_SUBTRACT = 8'h20;  // byte subtract
  localparam logic [7:0] SEL_STACK_BYTE_SUBTRACT_BORROW = 8'h30;  // byte sub with borrow
  localparam logic [7:0] SEL_STACK_WORD_SUBTRACT = 8'ha0;  // word subtract
  localparam logic [7:0] SEL_STACK_WORD_SUBTRACT_BORROW = 8'hb0;  // word sub with borrow

  // ----------------------------------------------------------------------------
  // steps and reset values
  // ----------------------------------------------------------------------------
  localparam logic [15:0] PC_STEP = 16'h0002;  // prefix plus selector
  localparam logic [15:0] SP_STEP = 16'h0001;  // one byte per decrement
  localparam logic [7:0] BYTE_RESET = 8'h00;  // data registers after reset
  localparam logic [15:0] WORD_RESET = 16'h0000;  // pointers after reset
  localparam int BYTE_NIBBLE_EDGE = 4;  // aux borrow boundary, byte forms
  localparam int WORD_NIBBLE_EDGE = 12;  // aux borrow boundary, word forms

  // ----------------------------------------------------------------------------
  // operation and sequencer types
  // ----------------------------------------------------------------------------
  typedef enum {
    OP_NONE,
    OP_WORD_OR,
    OP_BYTE_SUB,
    OP_BYTE_SUBB,
    OP_WORD_SUB,
    OP_WORD_SUBB
  } op_type;

  typedef enum {
    ST_IDLE,
    ST_BYTE_WAIT,
    ST_BYTE_TAKE,
    ST_WORD_WAIT,
    ST_WORD_TAKE_LO,
    ST_WORD_TAKE_HI
  } state_type;

endpackage : stack_alu_pkg

// file: src/stack_operand_alu_ops.sv
`timescale 1ns/1ps
// Operation
// - word or: pair or stacked word, flags kept
// - byte subtract: accumulator minus stacked byte
// - byte subtract with borrow also takes carry as borrow
// - word subtract: pair minus stacked word
// - word subtract with borrow also takes carry as borrow
// - byte forms read at pointer, decrement once
// - word forms decrement, read word, decrement again
// - program counter advances by two
module stack_operand_alu_ops
  import stack_alu_pkg::*;
(
  input wire logic i_clk_sys,  // core clock
  input wire logic i_rst,  // async, active high
  input wire logic i_start,  // one-cycle request from decode
  input wire logic [7:0] i_prefix,  // first instruction byte
  input wire logic [7:0] i_selector,  // second instruction byte
  input wire logic [7:0] i_acc,  // accumulator at start
  input wire logic [7:0] i_breg,  // high register of the pair at start
  input wire logic [15:0] i_stack_pointer,  // stack pointer at start
  input wire logic [15:0] i_pc,  // program counter at start
  input wire logic i_carry_flag,  // flags at start
  input wire logic i_aux_carry_flag,
  input wire logic i_overflow_flag,
  input wire logic [7:0] i_ram_rdata,  // ram byte, valid one cycle after read
  output logic [15:0] o_ram_addr,  // ram read address
  output logic o_ram_rd,  // ram read strobe
  output logic o_busy,  // instruction in progress
  output logic o_done,  // one-cycle completion pulse
  output logic o_unsupported,  // one-cycle pulse: request not in this group
  output logic [7:0] o_acc,  // results, held until next completion
  output logic [7:0] o_breg,
  output logic [15:0] o_stack_pointer,
  output logic [15:0] o_pc,
  output logic o_carry_flag,
  output logic o_aux_carry_flag,
  output logic o_overflow_flag
);

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  // maps the two instruction bytes onto an operation of this group
  function automatic op_type decode_op(input logic [7:0] prefix, input logic [7:0] sel);
    op_type op;
    op = OP_NONE;
    if (prefix == PREFIX_CODE) begin
      unique case (sel)
        SEL_STACK_WORD_OR: op = OP_WORD_OR;
        SEL_STACK_BYTE_SUBTRACT: op = OP_BYTE_SUB;
        SEL_STACK_BYTE_SUBTRACT_BORROW: op = OP_BYTE_SUBB;
        SEL_STACK_WORD_SUBTRACT: op = OP_WORD_SUB;
        SEL_STACK_WORD_SUBTRACT_BORROW: op = OP_WORD_SUBB;
        default: op = OP_NONE;  // other selectors belong elsewhere
      endcase
    end
    return op;
  endfunction : decode_op

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  state_type state_q, state_d;  // sequencer
  op_type op_q, op_d;  // operation in flight
  logic [7:0] acc_q, acc_d;  // captured accumulator
  logic [7:0] breg_q, breg_d;  // captured high register
  logic [15:0] sp_q, sp_d;  // captured stack pointer
  logic [15:0] pc_q, pc_d;  // captured program counter
  logic cy_q, cy_d;  // captured flags
  logic ac_q, ac_d;
  logic ov_q, ov_d;
  logic [7:0] low_byte_q, low_byte_d;  // low half of stacked word
  logic [15:0] ram_addr_q, ram_addr_d;
  logic ram_rd_q, ram_rd_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic unsup_q, unsup_d;
  logic [7:0] out_acc_q, out_acc_d;
  logic [7:0] out_breg_q, out_breg_d;
  logic [15:0] out_sp_q, out_sp_d;
  logic [15:0] out_pc_q, out_pc_d;
  logic out_cy_q, out_cy_d;
  logic out_ac_q, out_ac_d;
  logic out_ov_q, out_ov_d;

  // ----------------------------------------------------------------------------
  // arithmetic units
  // ----------------------------------------------------------------------------
  logic borrow_in;  // carry used only by the borrow forms
  logic [7:0] byte_diff;
  logic byte_cy, byte_ac, byte_ov;
  logic [15:0] word_diff;
  logic byte_borrow_form;
  logic [15:0] pair_value;  // high register over accumulator
  logic [15:0] stack_word;  // higher address over lower address

  assign byte_borrow_form = (op_q == OP_BYTE_SUBB);
  assign borrow_in = (byte_borrow_form || op_q == OP_WORD_SUBB) && cy_q;
  assign pair_value = {breg_q, acc_q};
  assign stack_word = {i_ram_rdata, low_byte_q};
  logic word_cy, word_ac, word_ov;

  // separate units keep each aux boundary a plain constant
  stack_sub_unit #(
    .WIDTH(8),
    .NIBBLE_EDGE(BYTE_NIBBLE_EDGE)
  ) byte_sub (
    .i_minuend(acc_q),
    .i_subtrahend(i_ram_rdata),
    .i_borrow_in(borrow_in),
    .o_diff(byte_diff),
    .o_carry(byte_cy),
    .o_aux_carry(byte_ac),
    .o_overflow(byte_ov)
  );

  // aux borrow for word forms sits at the high byte's nibble edge
  stack_sub_unit #(
    .WIDTH(16),
    .NIBBLE_EDGE(WORD_NIBBLE_EDGE)
  ) word_sub (
    .i_minuend(pair_value),
    .i_subtrahend(stack_word),
    .i_borrow_in(borrow_in),
    .o_diff(word_diff),
    .o_carry(word_cy),
    .o_aux_carry(word_ac),
    .o_overflow(word_ov)
  );

  // ----------------------------------------------------------------------------
  // sequencer next values
  // ----------------------------------------------------------------------------
  always_comb begin
    op_type req_op;
    req_op = decode_op(i_prefix, i_selector);
    state_d = state_q;
    op_d = op_q;
    acc_d = acc_q;
    breg_d = breg_q;
    sp_d = sp_q;
    pc_d = pc_q;
    cy_d = cy_q;
    ac_d = ac_q;
    ov_d = ov_q;
    low_byte_d = low_byte_q;
    ram_addr_d = ram_addr_q;
    ram_rd_d = 1'b0;
    done_d = 1'b0;
    unsup_d = 1'b0;
    out_acc_d = out_acc_q;
    out_breg_d = out_breg_q;
    out_sp_d = out_sp_q;
    out_pc_d = out_pc_q;
    out_cy_d = out_cy_q;
    out_ac_d = out_ac_q;
    out_ov_d = out_ov_q;
    unique case (state_q)
      ST_IDLE: begin
        // requests are only looked at here, so one while busy is dropped
        if (i_start) begin
          op_d = req_op;
          acc_d = i_acc;
          breg_d = i_breg;
          sp_d = i_stack_pointer;
          pc_d = i_pc;
          cy_d = i_carry_flag;
          ac_d = i_aux_carry_flag;
          ov_d = i_overflow_flag;
          unique case (req_op)
            OP_BYTE_SUB, OP_BYTE_SUBB: begin
              ram_addr_d = i_stack_pointer;
              ram_rd_d = 1'b1;
              state_d = ST_BYTE_WAIT;
            end
            OP_WORD_OR, OP_WORD_SUB, OP_WORD_SUBB: begin
              ram_addr_d = i_stack_pointer - SP_STEP;
              ram_rd_d = 1'b1;
              state_d = ST_WORD_WAIT;
            end
            OP_NONE: begin
              unsup_d = 1'b1;  // nothing changes, decode must route it
            end
          endcase
        end
      end
      ST_BYTE_WAIT: begin
        state_d = ST_BYTE_TAKE;  // ram answers next cycle
      end
      ST_BYTE_TAKE: begin
        out_acc_d = byte_diff;
        out_breg_d = breg_q;
        out_cy_d = byte_cy;
        out_ac_d = byte_ac;
        out_ov_d = byte_ov;
        out_sp_d = sp_q - SP_STEP;
        out_pc_d = pc_q + PC_STEP;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_WORD_WAIT: begin
        ram_addr_d = sp_q;  // high half at the higher address
        ram_rd_d = 1'b1;
        state_d = ST_WORD_TAKE_LO;
      end
      ST_WORD_TAKE_LO: begin
        low_byte_d = i_ram_rdata;  // pairs with the accumulator
        state_d = ST_WORD_TAKE_HI;
      end
      ST_WORD_TAKE_HI: begin
        if (op_q == OP_WORD_OR) begin
          {out_breg_d, out_acc_d} = pair_value | stack_word;
          out_cy_d = cy_q;  // flags pass through untouched
          out_ac_d = ac_q;
          out_ov_d = ov_q;
        end else begin
          {out_breg_d, out_acc_d} = word_diff;
          out_cy_d = word_cy;
          out_ac_d = word_ac;
          out_ov_d = word_ov;
        end
        out_sp_d = sp_q - SP_STEP - SP_STEP;  // both decrements
        out_pc_d = pc_q + PC_STEP;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      acc_q <= BYTE_RESET;
      breg_q <= BYTE_RESET;
      sp_q <= WORD_RESET;
      pc_q <= WORD_RESET;
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      low_byte_q <= BYTE_RESET;
      ram_addr_q <= WORD_RESET;
      ram_rd_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      unsup_q <= 1'b0;
      out_acc_q <= BYTE_RESET;
      out_breg_q <= BYTE_RESET;
      out_sp_q <= WORD_RESET;
      out_pc_q <= WORD_RESET;
      out_cy_q <= 1'b0;
      out_ac_q <= 1'b0;
      out_ov_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      acc_q <= acc_d;
      breg_q <= breg_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      cy_q <= cy_d;
      ac_q <= ac_d;
      ov_q <= ov_d;
      low_byte_q <= low_byte_d;
      ram_addr_q <= ram_addr_d;
      ram_rd_q <= ram_rd_d;
      busy_q <= busy_d;
      done_q <= done_d;
      unsup_q <= unsup_d;
      out_acc_q <= out_acc_d;
      out_breg_q <= out_breg_d;
      out_sp_q <= out_sp_d;
      out_pc_q <= out_pc_d;
      out_cy_q <= out_cy_d;
      out_ac_q <= out_ac_d;
      out_ov_q <= out_ov_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------------
  assign o_ram_addr = ram_addr_q;
  assign o_ram_rd = ram_rd_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_unsupported = unsup_q;
  assign o_acc = out_acc_q;
  assign o_breg = out_breg_q;
  assign o_stack_pointer = out_sp_q;
  assign o_pc = out_pc_q;
  assign o_carry_flag = out_cy_q;
  assign o_aux_carry_flag = out_ac_q;
  assign o_overflow_flag = out_ov_q;

endmodule : stack_operand_alu_ops

// file: src/stack_sub_unit.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// subtractor with borrow, aux borrow and signed overflow
// ----------------------------------------------------------------------------
module stack_sub_unit #(
  parameter int WIDTH = 8,  // operand width
  parameter int NIBBLE_EDGE = 4  // bit position whose borrow feeds aux flag
) (
  input wire logic [WIDTH-1:0] i_minuend,  // register side
  input wire logic [WIDTH-1:0] i_subtrahend,  // stack side
  input wire logic i_borrow_in,  // carry flag for borrow forms, else zero
  output logic [WIDTH-1:0] o_diff,  // difference
  output logic o_carry,  // borrow out of top bit
  output logic o_aux_carry,  // borrow out of nibble boundary
  output logic o_overflow  // two's complement overflow
);

  logic [WIDTH:0] full_diff;  // one extra bit catches the borrow
  logic [NIBBLE_EDGE:0] part_diff;  // low part only, for aux borrow

  // ----------------------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------------------
  always_comb begin
    full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {{WIDTH{1'b0}}, i_borrow_in};
    part_diff = {1'b0, i_minuend[NIBBLE_EDGE-1:0]} - {1'b0, i_subtrahend[NIBBLE_EDGE-1:0]}
              - {{NIBBLE_EDGE{1'b0}}, i_borrow_in};
    o_diff = full_diff[WIDTH-1:0];
    o_carry = full_diff[WIDTH];
    o_aux_carry = part_diff[NIBBLE_EDGE];
    // signs differ and result sign left the minuend's: signed overflow
    o_overflow = (i_minuend[WIDTH-1] != i_subtrahend[WIDTH-1])
               && (full_diff[WIDTH-1] != i_minuend[WIDTH-1]);
  end

endmodule : stack_sub_unit
